//--- adc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_cfg.svh"

module adc_ctrl
    import adc_ctrl_pkg::*;
#(
    parameter int CONV_TICKS = 11                  // Converter cycles per conversion
) (
    input  wire logic        ref_clk_in,           // System clock
    input  wire logic        srst_in,              // Synchronous reset
    input  wire logic        hsel_in,              // AHB select
    input  wire logic [31:0] haddr_in,             // AHB address
    input  wire logic [1:0]  htrans_in,            // AHB transfer type
    input  wire logic        hwrite_in,            // AHB write
    input  wire logic [2:0]  hsize_in,             // AHB size
    input  wire logic        hready_in,            // AHB ready
    input  wire logic [31:0] hwdata_in,            // AHB write data
    output logic      [31:0] hrdata_out,           // AHB read data
    output logic             hreadyout_out,        // AHB slave ready
    output logic             hresp_out,            // AHB response
    input  wire logic        standby_in,           // Standby sleep
    input  wire logic        power_down_in,        // Power-down sleep
    input  wire logic        event_start_in,       // Start event, async
    input  wire logic [9:0]  adc_code_in,          // Analog core code, async
    output logic      [4:0]  mux_select_out,       // Input channel
    output logic      [1:0]  ref_select_out,       // Reference choice
    output logic             sample_cap_out,       // Sample cap size
    output logic             converter_on_out,     // Analog core on
    output logic             sampling_out,         // Sampling window
    output logic             clock_request_out,    // Clock request
    output logic             result_invalid_out,   // Last result invalid
    output logic             irq_out               // Interrupt request
);

    logic [7:0]  ctl_reg, accum_reg, refpre_reg, delay_reg;
    logic [7:0]  winmode_reg, samplen_reg, mux_reg, ev_en_reg;
    logic [7:0]  dbg_reg, temp_reg;
    logic [1:0]  inten_reg, flags_reg, flag_set, flag_clr;
    logic [15:0] win_lo_reg, win_hi_reg, result_reg, acc_reg, acc_next;
    logic        wr_pend_reg, start_reg, init_pend_reg, en_q_reg;
    logic [5:0]  wr_idx_reg;
    logic [31:0] rdata_reg;
    logic [7:0]  wbyte;
    logic [9:0]  code_s1_reg, code_s2_reg, sample;
    logic [2:0]  ev_sync_reg;
    logic [7:0]  pre_cnt_reg;
    logic [8:0]  tick_cnt_reg, init_len;
    logic [6:0]  samp_idx_reg, samp_last;
    logic        pd_hit_reg, invalid_reg;
    conv_state_t state_reg;
    logic        addr_ok, rd_res, active, tick, ev_rise, done, win_hit;
    logic [5:0]  a_idx;
    logic [8:0]  samp_len;

    // Bus decode; the slave never inserts wait states
    assign a_idx   = haddr_in[7:2];
    assign addr_ok = hsel_in && hready_in && htrans_in[1];
    assign rd_res  = addr_ok && !hwrite_in && (a_idx == `IDX_RESULT);
    assign wbyte   = hwdata_in[7:0];
    assign hreadyout_out = 1'b1;
    assign hresp_out     = 1'b0;
    assign hrdata_out    = rdata_reg;

    // Address phase capture and registered read data
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            wr_pend_reg <= 1'b0;
            wr_idx_reg  <= 6'h00;
            rdata_reg   <= 32'h0000_0000;
        end else begin
            wr_pend_reg <= addr_ok && hwrite_in;
            wr_idx_reg  <= a_idx;
            if (addr_ok && !hwrite_in) begin
                case (a_idx)
                    `IDX_CTL:      rdata_reg <= {24'h0, ctl_reg};
                    `IDX_ACCUM:    rdata_reg <= {24'h0, accum_reg};
                    `IDX_REFPRE:   rdata_reg <= {24'h0, refpre_reg};
                    `IDX_DELAY:    rdata_reg <= {24'h0, delay_reg};
                    `IDX_WINMODE:  rdata_reg <= {24'h0, winmode_reg};
                    `IDX_SAMPLEN:  rdata_reg <= {24'h0, samplen_reg};
                    `IDX_MUXSEL:   rdata_reg <= {24'h0, mux_reg};
                    `IDX_COMMAND:  rdata_reg <= {31'h0, start_reg};
                    `IDX_EVIN:     rdata_reg <= {24'h0, ev_en_reg};
                    `IDX_INTEN:    rdata_reg <= {30'h0, inten_reg};
                    `IDX_FLAGS:    rdata_reg <= {30'h0, flags_reg};
                    `IDX_DBG:      rdata_reg <= {24'h0, dbg_reg};
                    `IDX_TEMP:     rdata_reg <= {24'h0, temp_reg};
                    `IDX_RESULT:   rdata_reg <= {16'h0, result_reg};
                    `IDX_WIN_LO:   rdata_reg <= {16'h0, win_lo_reg};
                    `IDX_WIN_HI:   rdata_reg <= {16'h0, win_hi_reg};
                    default:       rdata_reg <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration registers, written in the data phase
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            ctl_reg     <= `RST_BYTE;
            accum_reg   <= `RST_BYTE;
            refpre_reg  <= `RST_BYTE;
            delay_reg   <= `RST_BYTE;
            winmode_reg <= `RST_BYTE;
            samplen_reg <= `RST_BYTE;
            mux_reg     <= `RST_BYTE;
            ev_en_reg   <= `RST_BYTE;
            inten_reg   <= 2'b00;
            dbg_reg     <= `RST_BYTE;
            temp_reg    <= `RST_BYTE;
            win_lo_reg  <= `RST_WORD;
            win_hi_reg  <= `RST_WORD;
        end else if (wr_pend_reg) begin
            case (wr_idx_reg)
                `IDX_CTL:     ctl_reg     <= wbyte & `MASK_CTL;
                `IDX_ACCUM:   accum_reg   <= {5'h0, wbyte[2:0]};
                `IDX_REFPRE:  refpre_reg  <= wbyte & `MASK_REFPRE;
                `IDX_DELAY:   delay_reg   <= wbyte;
                `IDX_WINMODE: winmode_reg <= {5'h0, wbyte[2:0]};
                `IDX_SAMPLEN: samplen_reg <= {3'h0, wbyte[4:0]};
                `IDX_MUXSEL:  mux_reg     <= {3'h0, wbyte[4:0]};
                `IDX_EVIN:    ev_en_reg   <= {7'h0, wbyte[0]};
                `IDX_INTEN:   inten_reg   <= wbyte[1:0];
                `IDX_DBG:     dbg_reg     <= {7'h0, wbyte[0]};
                `IDX_TEMP:    temp_reg    <= wbyte;
                `IDX_WIN_LO:  win_lo_reg  <= hwdata_in[15:0];
                `IDX_WIN_HI:  win_hi_reg  <= hwdata_in[15:0];
                default:      ;
            endcase
        end
    end

    // Two-flop synchronisers for the analog code and start event
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            code_s1_reg <= 10'h000;
            code_s2_reg <= 10'h000;
            ev_sync_reg <= 3'b000;
        end else begin
            code_s1_reg <= adc_code_in;
            code_s2_reg <= code_s1_reg;
            ev_sync_reg <= {ev_sync_reg[1:0], event_start_in};
        end
    end

    // Off in standby unless run-in-standby; power-down only freezes
    assign active  = ctl_reg[`BIT_ENABLE]
                     && !(standby_in && !ctl_reg[`BIT_RUN_SB]);
    assign ev_rise = ev_sync_reg[1] && !ev_sync_reg[2] && ev_en_reg[0];

    // Prescaler: tick every 2^(code+1) system clocks
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !active) begin
            pre_cnt_reg <= 8'h00;
        end else if (!power_down_in) begin
            pre_cnt_reg <= tick ? 8'h00 : pre_cnt_reg + 8'h01;
        end
    end
    assign tick = active && !power_down_in
                  && (pre_cnt_reg == 8'((9'h002 << refpre_reg[2:0]) - 9'h001));

    // Lengths of the initial delay, one sample and one accumulation run
    assign init_len  = (delay_reg[7:5] > `INIT_MAX_CODE) ?
                       (`INIT_UNIT << 4) :
                       9'(`INIT_UNIT << (delay_reg[7:5] - 3'h1));
    assign samp_len  = 9'({3'h0, `SAMPLE_BASE} + {4'h0, samplen_reg[4:0]} + CONV_TICKS);
    assign samp_last = (accum_reg[2:0] == `ACC_RESERVED) ? 7'h00 :
                       7'((8'h01 << accum_reg[2:0]) - 8'h01);
    assign sample    = ctl_reg[`BIT_RES8] ? {2'b00, code_s2_reg[9:2]} :
                       code_s2_reg;
    assign acc_next  = acc_reg + {6'h00, sample};
    assign done      = (state_reg == ST_SAMPLE) && tick
                       && (tick_cnt_reg == samp_len - 9'h001)
                       && (samp_idx_reg == samp_last);

    // Start bit: command write outside standby, or event edge while active (standby only with run-in-standby)
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !ctl_reg[`BIT_ENABLE]) begin
            start_reg <= 1'b0;
        end else if (done) begin
            start_reg <= 1'b0;
        end else if (ev_rise && active) begin
            start_reg <= 1'b1;
        end else if (wr_pend_reg && wr_idx_reg == `IDX_COMMAND && !standby_in) begin
            start_reg <= wbyte[0];
        end
    end

    // Initial delay armed each time the converter is switched on
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            en_q_reg      <= 1'b0;
            init_pend_reg <= 1'b0;
        end else begin
            en_q_reg <= active;
            if (active && !en_q_reg) begin
                init_pend_reg <= 1'b1;
            end else if (state_reg == ST_INIT) begin
                init_pend_reg <= 1'b0;
            end
        end
    end

    // Conversion sequencer; holds its place through power-down
    always_ff @(posedge ref_clk_in) begin
        if (srst_in || !active) begin
            state_reg    <= ST_IDLE;
            tick_cnt_reg <= 9'h000;
            samp_idx_reg <= 7'h00;
            acc_reg      <= `RST_WORD;
        end else if (tick) begin
            case (state_reg)
                ST_IDLE: begin
                    tick_cnt_reg <= 9'h000;
                    samp_idx_reg <= 7'h00;
                    acc_reg      <= `RST_WORD;
                    if (start_reg) begin
                        state_reg <= (init_pend_reg && delay_reg[7:5] != 3'h0) ?
                                     ST_INIT : ST_SAMPLE;
                    end
                end
                ST_INIT: begin
                    tick_cnt_reg <= tick_cnt_reg + 9'h001;
                    if (tick_cnt_reg == init_len - 9'h001) begin
                        tick_cnt_reg <= 9'h000;
                        state_reg    <= ST_SAMPLE;
                    end
                end
                ST_SAMPLE: begin
                    tick_cnt_reg <= tick_cnt_reg + 9'h001;
                    if (tick_cnt_reg == samp_len - 9'h001) begin
                        tick_cnt_reg <= 9'h000;
                        acc_reg      <= acc_next;
                        samp_idx_reg <= samp_idx_reg + 7'h01;
                        if (done) begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end

    // Window compare runs once on the final accumulated value
    always_comb begin
        case (winmode_reg[2:0])
            `WIN_BELOW:   win_hit = acc_next < win_lo_reg;
            `WIN_ABOVE:   win_hit = acc_next > win_hi_reg;
            `WIN_INSIDE:  win_hit = acc_next > win_lo_reg && acc_next < win_hi_reg;
            `WIN_OUTSIDE: win_hit = acc_next < win_lo_reg || acc_next > win_hi_reg;
            default:      win_hit = 1'b0;
        endcase
    end

    // Result store; a conversion that spanned power-down is flagged invalid
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            result_reg  <= `RST_WORD;
            pd_hit_reg  <= 1'b0;
            invalid_reg <= 1'b0;
        end else begin
            if (power_down_in && state_reg != ST_IDLE) begin
                pd_hit_reg <= 1'b1;
            end
            if (done) begin
                result_reg  <= acc_next;
                invalid_reg <= pd_hit_reg;
                pd_hit_reg  <= 1'b0;
            end
        end
    end

    // Sticky flags: a set in the same cycle as a clear wins
    always_comb begin
        flag_set = {done && win_hit, done};
        flag_clr = 2'b00;
        if (wr_pend_reg && (wr_idx_reg == `IDX_FLAGS || wr_idx_reg == `IDX_INTCLR)) begin
            flag_clr = wbyte[1:0];
        end
        if (rd_res) begin
            flag_clr[`BIT_RDY] = 1'b1;
        end
    end
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            flags_reg <= 2'b00;
        end else begin
            flags_reg <= (flags_reg & ~flag_clr) | flag_set;
        end
    end
    assign irq_out = |(flags_reg & inten_reg);

    // Analog side controls; channel and reference held during a conversion
    always_ff @(posedge ref_clk_in) begin
        if (srst_in) begin
            mux_select_out     <= 5'h00;
            ref_select_out     <= 2'b00;
            sample_cap_out     <= 1'b0;
            converter_on_out   <= 1'b0;
            sampling_out       <= 1'b0;
            clock_request_out  <= 1'b0;
            result_invalid_out <= 1'b0;
        end else begin
            if (state_reg == ST_IDLE) begin
                mux_select_out <= mux_reg[4:0];
                ref_select_out <= refpre_reg[5:4];
                sample_cap_out <= refpre_reg[6];
            end
            converter_on_out   <= active;
            sampling_out       <= state_reg == ST_SAMPLE
                                  && tick_cnt_reg < 9'({3'h0, `SAMPLE_BASE} + samplen_reg[4:0]);
            clock_request_out  <= standby_in && active
                                  && (start_reg || state_reg != ST_IDLE);
            result_invalid_out <= invalid_reg;
        end
    end

    // Checks
    sequence s_res_read;
        rd_res && !done;
    endsequence
    sequence s_done_evt;
        done;
    endsequence

    property p_result_ready_set;
        @(posedge ref_clk_in) disable iff (srst_in) s_done_evt |=> flags_reg[0];
    endproperty
    a_result_ready_set: assert property (p_result_ready_set) else $error("done without ready flag");

    property p_win_none;
        @(posedge ref_clk_in) disable iff (srst_in)
            done && winmode_reg[2:0] == `WIN_NONE && !flags_reg[`BIT_WIN] |=> !flags_reg[`BIT_WIN];
    endproperty
    a_win_none: assert property (p_win_none) else $error("window flag set with mode none");

    // Request stays up until a flag clear or an enable write takes it down
    property p_irq;
        @(posedge ref_clk_in) disable iff (srst_in)
            irq_out && flag_clr == 2'b00 && !(wr_pend_reg && wr_idx_reg == `IDX_INTEN)
            |=> irq_out;
    endproperty
    a_irq: assert property (p_irq) else $error("irq mismatch");

    property p_read_clear;
        @(posedge ref_clk_in) disable iff (srst_in) s_res_read |=> !flags_reg[0];
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("result read kept flag");

    property p_standby_off;
        @(posedge ref_clk_in) disable iff (srst_in)
            standby_in && !ctl_reg[`BIT_RUN_SB] |=> state_reg == ST_IDLE;
    endproperty
    a_standby_off: assert property (p_standby_off) else $error("ran in standby");

    property p_freeze;
        @(posedge ref_clk_in) disable iff (srst_in)
            power_down_in && active |=> $stable(tick_cnt_reg) && $stable(state_reg);
    endproperty
    a_freeze: assert property (p_freeze) else $error("moved in power down");

    property p_start_clear;
        @(posedge ref_clk_in) disable iff (srst_in) done |=> !start_reg;
    endproperty
    a_start_clear: assert property (p_start_clear) else $error("start bit stuck");

    property p_event_start;
        @(posedge ref_clk_in) disable iff (srst_in)
            ev_rise && active && !done && ctl_reg[`BIT_ENABLE] |=> start_reg;
    endproperty
    a_event_start: assert property (p_event_start) else $error("event missed");

    property p_disabled;
        @(posedge ref_clk_in) disable iff (srst_in)
            !ctl_reg[`BIT_ENABLE] |=> !start_reg && !converter_on_out;
    endproperty
    a_disabled: assert property (p_disabled) else $error("ran while disabled");

    property p_result;
        @(posedge ref_clk_in) disable iff (srst_in) done |=> result_reg == $past(acc_next);
    endproperty
    a_result: assert property (p_result) else $error("result not stored");

endmodule
`default_nettype wire

//--- adc_ctrl_cfg.svh
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH
// Register indices; byte address is four times the index
`define IDX_CTL        6'h00
`define IDX_ACCUM      6'h01
`define IDX_REFPRE     6'h02
`define IDX_DELAY      6'h03
`define IDX_WINMODE    6'h04
`define IDX_SAMPLEN    6'h05
`define IDX_MUXSEL     6'h06
`define IDX_COMMAND    6'h08
`define IDX_EVIN       6'h09
`define IDX_INTEN      6'h0A
`define IDX_FLAGS      6'h0B
`define IDX_DBG        6'h0C
`define IDX_TEMP       6'h0D
`define IDX_RESULT     6'h10
`define IDX_WIN_LO     6'h12
`define IDX_WIN_HI     6'h14
`define IDX_INTCLR     6'h18
// Field positions
`define BIT_ENABLE     0
`define BIT_RES8       2
`define BIT_RUN_SB     7
`define BIT_RDY        0
`define BIT_WIN        1
// Writable masks and reset values
`define MASK_CTL       8'h85
`define MASK_REFPRE    8'h77
`define RST_BYTE       8'h00
`define RST_WORD       16'h0000
// Encodings
`define ACC_RESERVED   3'h7
`define WIN_NONE       3'h0
`define WIN_BELOW      3'h1
`define WIN_ABOVE      3'h2
`define WIN_INSIDE     3'h3
`define WIN_OUTSIDE    3'h4
// Timing in converter clock cycles
`define SAMPLE_BASE    6'h02
`define INIT_UNIT      9'h010
`define INIT_MAX_CODE  3'h5
`endif

//--- adc_ctrl_pkg.sv
package adc_ctrl_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_INIT,
        ST_SAMPLE
    } conv_state_t;
endpackage

//--- adc_core_model.sv
`timescale 1ns/100ps
`default_nettype none
module adc_core_model (
    input  wire logic       clk_in,     // System clock
    input  wire logic       on_in,      // Core powered
    input  wire logic [9:0] level_in,   // Input voltage as a code
    input  wire logic       fire_in,    // Request one start event
    output logic      [9:0] code_out,   // Converted code
    output logic            event_out   // Start event line
);
    logic [9:0] noise_reg = 10'h000;
    logic [2:0] pulse_reg = 3'h0;
    // An unpowered core has no stable code, so show a moving pattern
    always_ff @(posedge clk_in) begin
        noise_reg <= noise_reg + 10'h155;
    end
    assign code_out = on_in ? level_in : noise_reg;
    // Pulse held a few cycles so the two-flop synchroniser sees the edge
    always_ff @(posedge clk_in) begin
        if (fire_in) begin
            pulse_reg <= 3'h4;
        end else if (pulse_reg != 3'h0) begin
            pulse_reg <= pulse_reg - 3'h1;
        end
    end
    assign event_out = (pulse_reg != 3'h0);
endmodule
`default_nettype wire

//--- tb_adc_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "adc_ctrl_cfg.svh"
module tb_adc_ctrl;
    logic        ref_clk, srst, hwrite, hready, hresp, standby, power_down, fire, evt;
    logic [1:0]  htrans, ref_sel;
    logic [31:0] haddr, hwdata, hrdata;
    logic [9:0]  level, code;
    logic        conv_on, clk_req, res_inv, irq;
    int          fail_count, comparisons, cycles;
    logic [9:0]  lt, ht;
    logic        e;
    adc_ctrl #(.CONV_TICKS(1)) adc_ctrl_i (
        .ref_clk_in(ref_clk), .srst_in(srst), .hsel_in(1'b1), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hready_in(hready),
        .hwdata_in(hwdata), .hrdata_out(hrdata), .hreadyout_out(hready),
        .hresp_out(hresp), .standby_in(standby), .power_down_in(power_down),
        .event_start_in(evt), .adc_code_in(code), .mux_select_out(),
        .ref_select_out(ref_sel), .sample_cap_out(), .converter_on_out(conv_on),
        .sampling_out(), .clock_request_out(clk_req), .result_invalid_out(res_inv),
        .irq_out(irq));
    adc_core_model adc_core_model_i (.clk_in(ref_clk), .on_in(conv_on),
        .level_in(level), .fire_in(fire), .code_out(code), .event_out(evt));
    // Free-running 250 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // Hang guard: whole run needs under a thousand cycles
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            final_report();
        end
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // One AHB single transfer; each phase held until hready is seen high
    task automatic ahb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        haddr <= {24'h0, idx, 2'b00};
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [5:0] idx, input logic [31:0] d);
        logic [31:0] unused;
        ahb(1'b1, idx, d, unused);
        // Let the write land before anyone looks at what it drives
        @(posedge ref_clk);
    endtask
    task automatic chk(input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] got;
        ahb(1'b0, idx, 32'h0, got);
        check(got, exp);
        check({31'h0, hresp}, 32'h0);
    endtask
    // Poll the flags until result ready shows, bounded
    task automatic wait_done;
        logic [31:0] f;
        int n;
        f = 32'h0;
        for (n = 0; n < 400 && f[0] !== 1'b1; n++) ahb(1'b0, `IDX_FLAGS, 32'h0, f);
        check({31'h0, f[0]}, 32'h1);
    endtask
    task automatic run;
        wr(`IDX_COMMAND, 32'h1);
        wait_done();
    endtask
    // Main sequence
    initial begin
        srst = 1'b1;
        htrans = 2'b00;
        hwrite = 1'b0;
        haddr = 32'h0;
        hwdata = 32'h0;
        standby = 1'b0;
        power_down = 1'b0;
        fire = 1'b0;
        level = 10'h2A5;
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        @(posedge ref_clk);
        chk(`IDX_CTL, 32'h0);
        chk(`IDX_ACCUM, 32'h0);
        chk(`IDX_REFPRE, 32'h0);
        wr(6'h07, 32'hFF);
        chk(6'h07, 32'h0);
        wr(`IDX_CTL, 32'hFF);
        chk(`IDX_CTL, 32'h85);
        check({31'h0, conv_on}, 32'h1);
        wr(`IDX_CTL, 32'h0);
        chk(`IDX_CTL, 32'h0);
        check({31'h0, conv_on}, 32'h0);
        wr(`IDX_REFPRE, 32'hFF);
        chk(`IDX_REFPRE, 32'h77);
        for (int r = 0; r < 3; r++) begin
            wr(`IDX_REFPRE, 32'(r << 4));
            chk(`IDX_REFPRE, 32'(r << 4));
            check({30'h0, ref_sel}, 32'(r));
        end
        wr(`IDX_REFPRE, 32'h0);
        // Flag sets with its source disabled; request follows enable and clear
        wr(`IDX_CTL, 32'h1);
        run();
        check({31'h0, irq}, 32'h0);
        wr(`IDX_INTEN, 32'h1);
        check({31'h0, irq}, 32'h1);
        wr(`IDX_FLAGS, 32'h1);
        chk(`IDX_FLAGS, 32'h0);
        check({31'h0, irq}, 32'h0);
        chk(`IDX_RESULT, 32'h2A5);
        chk(`IDX_COMMAND, 32'h0);
        wr(`IDX_CTL, 32'h5);
        run();
        chk(`IDX_RESULT, 32'h2A5 >> 2);
        wr(`IDX_CTL, 32'h1);
        wr(`IDX_ACCUM, 32'h2);
        run();
        chk(`IDX_RESULT, 32'h2A5 * 4);
        // Every window mode on two threshold pairs, edges included
        wr(`IDX_ACCUM, 32'h0);
        wr(`IDX_INTEN, 32'h2);
        for (int p = 0; p < 2; p++) begin
            lt = (p == 0) ? 10'h2A6 : 10'h2A5;
            ht = (p == 0) ? 10'h2A4 : 10'h2A5;
            for (int m = 0; m < 5; m++) begin
                e = (m == 1) ? (10'h2A5 < lt) : (m == 2) ? (10'h2A5 > ht) :
                    (m == 3) ? (lt < 10'h2A5 && 10'h2A5 < ht) :
                    (m == 4) ? (10'h2A5 < lt || 10'h2A5 > ht) : 1'b0;
                wr(`IDX_WIN_LO, {22'h0, lt});
                wr(`IDX_WIN_HI, {22'h0, ht});
                wr(`IDX_WINMODE, 32'(m));
                wr(`IDX_INTCLR, 32'h3);
                run();
                chk(`IDX_FLAGS, {30'h0, e, 1'b1});
                check({31'h0, irq}, {31'h0, e});
            end
        end
        // Power-down in mid-conversion freezes it; result marked invalid
        wr(`IDX_WINMODE, 32'h0);
        wr(`IDX_ACCUM, 32'h3);
        wr(`IDX_FLAGS, 32'h3);
        wr(`IDX_COMMAND, 32'h1);
        repeat (10) @(posedge ref_clk);
        power_down <= 1'b1;
        repeat (100) @(posedge ref_clk);
        chk(`IDX_FLAGS, 32'h0);
        power_down <= 1'b0;
        wait_done();
        check({31'h0, res_inv}, 32'h1);
        // Standby with run bit: event starts it, clock held only while busy
        wr(`IDX_DELAY, 32'h20);
        wr(`IDX_EVIN, 32'h1);
        wr(`IDX_CTL, 32'h81);
        wr(`IDX_INTEN, 32'h1);
        wr(`IDX_FLAGS, 32'h3);
        standby <= 1'b1;
        fire <= 1'b1;
        @(posedge ref_clk);
        fire <= 1'b0;
        repeat (8) @(posedge ref_clk);
        check({31'h0, clk_req}, 32'h1);
        chk(`IDX_COMMAND, 32'h1);
        wait_done();
        chk(`IDX_COMMAND, 32'h0);
        check({31'h0, irq}, 32'h1);
        check({31'h0, clk_req}, 32'h0);
        chk(`IDX_RESULT, 32'h2A5 * 8);
        // Standby without the run bit shuts the core
        wr(`IDX_CTL, 32'h1);
        chk(`IDX_CTL, 32'h1);
        check({31'h0, conv_on}, 32'h0);
        standby <= 1'b0;
        chk(`IDX_CTL, 32'h1);
        check({31'h0, conv_on}, 32'h1);
        final_report();
    end
endmodule
`default_nettype wire
